// ---- hdl/csp_top.sv ----
// clock-synchronous serial port with apb register access
// Operation
// - sync mode when mode bits are 001
// - words are always eight bits
// - mode bit 3 picks internal or external clock
// - mode bits 4-7 stored but ignored
// - source clock divided by rate+1, then two
// - control0 bit 2 picks cts input or rts
// - start needs enable, full buffer, cts low when cts selected
// - data driven on falling clock, lsb first
// - buffer-empty clears on write, sets on load
// - shift register reloads automatically when start holds
// - rts selected means cts is ignored
// - enable, empty and cts ignored mid-word
// - start checked while end strobe is high
// - shift-empty sets cycle after end strobe rises
// - buffer-empty rising sets transmit request bit
// - receive enable bit enables reception
// - rts high when disabled or cts selected, low when ready
// - sample on rising clock, eight bits to buffer
// - buffer-full rising sets receive request bit
// - overrun when new word meets full buffer
// - buffer read clears full and overrun
`timescale 1ns/1ps
module csp_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_shift_clock_in,
  output logic             serial_shift_clock_out,
  output logic             serial_shift_clock_oe,
  output logic             serial_data_out,
  input  wire logic        serial_data_in,
  input  wire logic        clear_to_send_in_n,
  output logic             ready_to_receive_out_n
);
  typedef struct packed {
    logic [7:0]                 mode;
    logic [1:0]                 clk_src;
    logic                       hs_sel;
    logic [7:0]                 rate;
    logic                       te;
    logic                       ti;
    logic                       re;
    logic                       ri;
    logic                       oer;
    logic                       shift_empty;
    logic                       tx_irq;
    logic                       rx_irq;
    logic [7:0]                 txbuf;
    logic [7:0]                 rxbuf;
    csp_pkg::csp_tx_state_e     tx_state;
    logic [7:0]                 tx_sh;
    logic [3:0]                 tx_cnt;
    logic                       tx_end;
    logic                       txd;
    logic                       rts_n;
    logic                       sclk_oe;
    logic                       sclk_s1;
    logic                       sclk_s2;
    logic                       sclk_prev;
    logic                       rxd_s1;
    logic                       rxd_s2;
    logic                       cts_s1;
    logic                       cts_s2;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } csp_top_s;

  csp_top_s    s_reg;
  csp_top_s    s_next;
  csp_core_if  lnk ();
  logic        sync_on;
  logic        ext_clk;
  logic        fall_p;
  logic        rise_p;
  logic        start_ok;
  logic        setup;
  logic        access;
  logic [31:0] rd_word;
  logic        hit;

  csp_clk_gen u_clk_gen (
    .ref_clk (ref_clk),
    .reset   (reset),
    .lnk     (lnk.gen)
  );

  csp_rx_shift u_rx_shift (
    .ref_clk (ref_clk),
    .reset   (reset),
    .lnk     (lnk.rx)
  );

  // mode decode; bits 4 to 7 are stored but steer nothing here
  assign sync_on = s_reg.mode[csp_pkg::MODE_SEL0_B] &
                   ~s_reg.mode[csp_pkg::MODE_SEL1_B] &
                   ~s_reg.mode[csp_pkg::MODE_SEL2_B];
  assign ext_clk = s_reg.mode[csp_pkg::MODE_EXTCLK_B];

  // shift clock edges from the pin or from the generator
  assign fall_p = ext_clk ? (s_reg.sclk_prev & ~s_reg.sclk_s2) : lnk.int_fall;
  assign rise_p = ext_clk ? (~s_reg.sclk_prev & s_reg.sclk_s2) : lnk.int_rise;

  // cts only gates when selected as input
  assign start_ok = s_reg.te & ~s_reg.ti &
                    (s_reg.hs_sel | ~s_reg.cts_s2);

  // generator runs only while a word is shifting; source bits unused on external clock
  assign lnk.run     = sync_on & ~ext_clk & (s_reg.tx_state == csp_pkg::TX_SHIFT) &
                       ~(rise_p & (s_reg.tx_cnt == csp_pkg::LAST_BIT));
  assign lnk.clk_sel = s_reg.clk_src;
  assign lnk.rate    = s_reg.rate;
  assign lnk.rx_en   = sync_on & s_reg.re;
  assign lnk.rx_rise = rise_p;
  assign lnk.rx_bit  = s_reg.rxd_s2;

  assign setup  = psel & ~penable;
  assign access = psel & penable & s_reg.pready;

  // read data and address decode
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      csp_pkg::OFF_MODE: begin
        rd_word[7:0] = s_reg.mode;
      end
      csp_pkg::OFF_CTRL0: begin
        rd_word[csp_pkg::CTRL0_CS_LO_B]   = s_reg.clk_src[0];
        rd_word[csp_pkg::CTRL0_CS_HI_B]   = s_reg.clk_src[1];
        rd_word[csp_pkg::CTRL0_HS_B]      = s_reg.hs_sel;
        rd_word[csp_pkg::CTRL0_TXEMPTY_B] = s_reg.shift_empty;
      end
      csp_pkg::OFF_CTRL1: begin
        rd_word[csp_pkg::CTRL1_TE_B]  = s_reg.te;
        rd_word[csp_pkg::CTRL1_TI_B]  = s_reg.ti;
        rd_word[csp_pkg::CTRL1_RE_B]  = s_reg.re;
        rd_word[csp_pkg::CTRL1_RI_B]  = s_reg.ri;
        rd_word[csp_pkg::CTRL1_OER_B] = s_reg.oer;
      end
      csp_pkg::OFF_RATE: begin
        rd_word[7:0] = s_reg.rate;
      end
      csp_pkg::OFF_TXBUF: begin
        rd_word[7:0] = s_reg.txbuf;
      end
      csp_pkg::OFF_RXBUF: begin
        rd_word[7:0] = s_reg.rxbuf;
      end
      csp_pkg::OFF_IREQ: begin
        rd_word[csp_pkg::IREQ_TX_B] = s_reg.tx_irq;
        rd_word[csp_pkg::IREQ_RX_B] = s_reg.rx_irq;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // pin synchronisers
    s_next.sclk_s1   = serial_shift_clock_in;
    s_next.sclk_s2   = s_reg.sclk_s1;
    s_next.sclk_prev = s_reg.sclk_s2;
    s_next.rxd_s1    = serial_data_in;
    s_next.rxd_s2    = s_reg.rxd_s1;
    s_next.cts_s1    = clear_to_send_in_n;
    s_next.cts_s2    = s_reg.cts_s1;
    // apb: answer in the cycle after setup
    s_next.pready = setup;
    if (setup) begin
      s_next.prdata  = rd_word;
      s_next.pslverr = ~hit;
    end
    // transmitter
    if (!sync_on) begin
      s_next.tx_state = csp_pkg::TX_IDLE;
      s_next.tx_end   = 1'b1;
      s_next.txd      = 1'b1;
    end else begin
      unique case (s_reg.tx_state)
        csp_pkg::TX_IDLE: begin
          if (s_reg.tx_end && start_ok) begin
            s_next.tx_state    = csp_pkg::TX_SHIFT;
            s_next.tx_end      = 1'b0;
            s_next.tx_sh       = s_reg.txbuf;
            s_next.tx_cnt      = 4'h0;
            s_next.ti          = 1'b1;
            s_next.shift_empty = 1'b0;
          end else if (s_reg.tx_end) begin
            s_next.shift_empty = 1'b1;
          end
        end
        csp_pkg::TX_SHIFT: begin
          // enable, empty flag and cts are not looked at here
          if (fall_p) begin
            s_next.txd   = s_reg.tx_sh[0];
            s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
          end
          if (rise_p) begin
            if (s_reg.tx_cnt == csp_pkg::LAST_BIT) begin
              s_next.tx_state = csp_pkg::TX_IDLE;
              s_next.tx_end   = 1'b1;
            end else begin
              s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
            end
          end
        end
      endcase
    end
    // register writes take effect at the completing access edge
    if (access && pwrite && !s_reg.pslverr) begin
      unique case (paddr)
        csp_pkg::OFF_MODE: begin
          s_next.mode = pwdata[7:0];
        end
        csp_pkg::OFF_CTRL0: begin
          s_next.clk_src = {pwdata[csp_pkg::CTRL0_CS_HI_B], pwdata[csp_pkg::CTRL0_CS_LO_B]};
          s_next.hs_sel  = pwdata[csp_pkg::CTRL0_HS_B];
        end
        csp_pkg::OFF_CTRL1: begin
          s_next.te = pwdata[csp_pkg::CTRL1_TE_B];
          s_next.re = pwdata[csp_pkg::CTRL1_RE_B];
          if (!pwdata[csp_pkg::CTRL1_RE_B]) begin
            s_next.oer = 1'b0;
          end
        end
        csp_pkg::OFF_RATE: begin
          s_next.rate = pwdata[7:0];
        end
        csp_pkg::OFF_TXBUF: begin
          s_next.txbuf = pwdata[7:0];
          s_next.ti    = 1'b0;
        end
        csp_pkg::OFF_IREQ: begin
          s_next.tx_irq = s_reg.tx_irq & ~pwdata[csp_pkg::IREQ_TX_B];
          s_next.rx_irq = s_reg.rx_irq & ~pwdata[csp_pkg::IREQ_RX_B];
        end
        default: begin
        end
      endcase
    end
    // reading the receive buffer clears full and overrun
    if (access && !pwrite && (paddr == csp_pkg::OFF_RXBUF)) begin
      s_next.ri  = 1'b0;
      s_next.oer = 1'b0;
    end
    // received word lands in the buffer; set wins over clear
    if (lnk.rx_done) begin
      s_next.rxbuf = lnk.rx_word;
      s_next.ri    = 1'b1;
      if (s_reg.ri) begin
        s_next.oer = 1'b1;
      end
    end
    // request bits on rising flags
    if (s_next.ti && !s_reg.ti) begin
      s_next.tx_irq = 1'b1;
    end
    if (s_next.ri && !s_reg.ri) begin
      s_next.rx_irq = 1'b1;
    end
    // ready-to-receive: low while rts selected, enabled and no word in progress
    s_next.rts_n   = ~(sync_on & s_reg.hs_sel & s_reg.re & ~lnk.rx_active);
    s_next.sclk_oe = sync_on & ~ext_clk;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '{mode: csp_pkg::MODE_RST, clk_src: 2'h0, hs_sel: 1'b0,
                 rate: csp_pkg::RATE_RST, te: 1'b0, ti: 1'b1, re: 1'b0, ri: 1'b0,
                 oer: 1'b0, shift_empty: 1'b1, tx_irq: 1'b0, rx_irq: 1'b0,
                 txbuf: csp_pkg::BYTE_ZERO, rxbuf: csp_pkg::BYTE_ZERO,
                 tx_state: csp_pkg::TX_IDLE, tx_sh: csp_pkg::BYTE_ZERO, tx_cnt: 4'h0,
                 tx_end: 1'b1, txd: 1'b1, rts_n: 1'b1, sclk_oe: 1'b0,
                 sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_prev: 1'b1,
                 rxd_s1: 1'b1, rxd_s2: 1'b1, cts_s1: 1'b1, cts_s2: 1'b1,
                 prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata                 = s_reg.prdata;
  assign pready                 = s_reg.pready;
  assign pslverr                = s_reg.pslverr;
  assign serial_shift_clock_out = lnk.int_level;
  assign serial_shift_clock_oe  = s_reg.sclk_oe;
  assign serial_data_out        = s_reg.txd;
  assign ready_to_receive_out_n = s_reg.rts_n;
endmodule : csp_top

// ---- hdl/csp_pkg.sv ----
// constants and types shared by the clock-synchronous serial port
package csp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_MODE  = 8'h00;
  localparam logic [7:0] OFF_CTRL0 = 8'h04;
  localparam logic [7:0] OFF_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_RATE  = 8'h0C;
  localparam logic [7:0] OFF_TXBUF = 8'h10;
  localparam logic [7:0] OFF_RXBUF = 8'h14;
  localparam logic [7:0] OFF_IREQ  = 8'h18;
  // mode register fields
  localparam int MODE_SEL0_B   = 0;
  localparam int MODE_SEL1_B   = 1;
  localparam int MODE_SEL2_B   = 2;
  localparam int MODE_EXTCLK_B = 3;
  // control register 0 fields
  localparam int CTRL0_CS_LO_B   = 0;
  localparam int CTRL0_CS_HI_B   = 1;
  localparam int CTRL0_HS_B      = 2;
  localparam int CTRL0_TXEMPTY_B = 3;
  // control register 1 fields
  localparam int CTRL1_TE_B  = 0;
  localparam int CTRL1_TI_B  = 1;
  localparam int CTRL1_RE_B  = 2;
  localparam int CTRL1_RI_B  = 3;
  localparam int CTRL1_OER_B = 4;
  // interrupt request register fields
  localparam int IREQ_TX_B = 0;
  localparam int IREQ_RX_B = 1;
  // reset values
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] RATE_RST  = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // word length and the bit index of the last bit
  localparam int         WORD_BITS = 8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  // internal clock source dividers selected by the two source bits
  localparam logic [9:0] DIV_SRC0 = 10'h001;
  localparam logic [9:0] DIV_SRC1 = 10'h008;
  localparam logic [9:0] DIV_SRC2 = 10'h020;
  localparam logic [9:0] DIV_SRC3 = 10'h200;
  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } csp_tx_state_e;
endpackage : csp_pkg

// ---- hdl/csp_core_if.sv ----
// signals between the port core, its clock generator and its receiver
`timescale 1ns/1ps
interface csp_core_if;
  logic       run;
  logic [1:0] clk_sel;
  logic [7:0] rate;
  logic       int_fall;
  logic       int_rise;
  logic       int_level;
  logic       rx_en;
  logic       rx_rise;
  logic       rx_bit;
  logic [7:0] rx_word;
  logic       rx_done;
  logic       rx_active;
  modport gen  (input run, clk_sel, rate, output int_fall, int_rise, int_level);
  modport rx   (input rx_en, rx_rise, rx_bit, output rx_word, rx_done, rx_active);
  modport core (output run, clk_sel, rate, rx_en, rx_rise, rx_bit,
                input int_fall, int_rise, int_level, rx_word, rx_done, rx_active);
endinterface : csp_core_if

// ---- hdl/csp_clk_gen.sv ----
// internal shift clock generator: source divider, rate divider, divide by two
`timescale 1ns/1ps
module csp_clk_gen (
  input wire logic ref_clk,
  input wire logic reset,
  csp_core_if.gen  lnk
);
  typedef struct packed {
    logic [9:0] pre;
    logic [7:0] cnt;
    logic       level;
    logic       fall;
    logic       rise;
  } csp_gen_s;

  csp_gen_s   s_reg;
  csp_gen_s   s_next;
  logic [9:0] div;

  always_comb begin
    s_next      = s_reg;
    s_next.fall = 1'b0;
    s_next.rise = 1'b0;
    unique case (lnk.clk_sel)
      2'h0: div = csp_pkg::DIV_SRC0;
      2'h1: div = csp_pkg::DIV_SRC1;
      2'h2: div = csp_pkg::DIV_SRC2;
      2'h3: div = csp_pkg::DIV_SRC3;
    endcase
    if (!lnk.run) begin
      s_next.pre   = 10'h000;
      s_next.cnt   = 8'h00;
      s_next.level = 1'b1;
    end else if (s_reg.pre == div - 10'h001) begin
      s_next.pre = 10'h000;
      // half period is rate plus one source ticks
      if (s_reg.cnt == lnk.rate) begin
        s_next.cnt   = 8'h00;
        s_next.level = ~s_reg.level;
        s_next.fall  = s_reg.level;
        s_next.rise  = ~s_reg.level;
      end else begin
        s_next.cnt = s_reg.cnt + 8'h01;
      end
    end else begin
      s_next.pre = s_reg.pre + 10'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '{pre: 10'h000, cnt: 8'h00, level: 1'b1, fall: 1'b0, rise: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.int_fall  = s_reg.fall;
  assign lnk.int_rise  = s_reg.rise;
  assign lnk.int_level = s_reg.level;
endmodule : csp_clk_gen

// ---- hdl/csp_rx_shift.sv ----
// receive shift register: samples on rising shift clock, lsb first
`timescale 1ns/1ps
module csp_rx_shift (
  input wire logic ref_clk,
  input wire logic reset,
  csp_core_if.rx   lnk
);
  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] word;
    logic       done;
  } csp_rx_s;

  csp_rx_s s_reg;
  csp_rx_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (!lnk.rx_en) begin
      s_next.cnt = 4'h0;
    end else if (lnk.rx_rise) begin
      s_next.sh = {lnk.rx_bit, s_reg.sh[7:1]};
      if (s_reg.cnt == csp_pkg::LAST_BIT) begin
        s_next.cnt  = 4'h0;
        s_next.word = {lnk.rx_bit, s_reg.sh[7:1]};
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '{sh: 8'h00, cnt: 4'h0, word: 8'h00, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.rx_word   = s_reg.word;
  assign lnk.rx_done   = s_reg.done;
  assign lnk.rx_active = (s_reg.cnt != 4'h0);
endmodule : csp_rx_shift

// ---- verif/csp_top_props.sv ----
// port assertions for the clock-synchronous serial port
`timescale 1ns/1ps
module csp_top_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_shift_clock_out,
  input wire logic        serial_shift_clock_oe,
  input wire logic        serial_data_out,
  input wire logic        ready_to_receive_out_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic setup;
  assign setup = psel && !penable;
  a_pready_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (setup && !pwrite && paddr == 8'h1C
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (setup && paddr == csp_pkg::OFF_TXBUF |=> !pslverr)
    else $error("mapped access refused");
  a_idle_reset: assert property ($fell(reset) |-> serial_data_out && serial_shift_clock_out
    && ready_to_receive_out_n && !serial_shift_clock_oe)
    else $error("pins not idle after reset");
  // half periods assume rate 3 and source divider 1 as the bench sets
  // data is launched one clock after the registered fall of the driven shift clock
  a_data_on_fall: assert property ($changed(serial_data_out) && serial_shift_clock_oe
    |-> !serial_shift_clock_out && $past(serial_shift_clock_out, 2))
    else $error("data changed off a clock fall");
  a_low_half: assert property ($fell(serial_shift_clock_out)
    |-> !serial_shift_clock_out [*4] ##1 serial_shift_clock_out)
    else $error("low half period wrong");
  a_high_half: assert property ($rose(serial_shift_clock_out)
    |-> serial_shift_clock_out [*4])
    else $error("high half period short");
endmodule : csp_top_props
bind csp_top csp_top_props u_props (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_shift_clock_out(serial_shift_clock_out),
  .serial_shift_clock_oe(serial_shift_clock_oe), .serial_data_out(serial_data_out),
  .ready_to_receive_out_n(ready_to_receive_out_n));

// ---- verif/csp_peer.sv ----
// peer port on external clock: sends and receives eight bits lsb first
`timescale 1ns/1ps
module csp_peer (
  input  wire logic       ref_clk,
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic [7:0] tx_base,
  output logic            sdi,
  output logic [7:0]      rx_word,
  output logic [7:0]      n_words
);
  logic       sck_d;
  logic [2:0] cnt;
  logic [7:0] sh;
  logic [7:0] w;
  initial begin
    sck_d = 1'h1;
    cnt = 3'h0;
    sh = 8'h00;
    sdi = 1'h1;
    rx_word = 8'h00;
    n_words = 8'h00;
  end
  always @(posedge ref_clk) begin
    sck_d <= sck;
    w = tx_base + n_words;
    if (sck_d && !sck) begin
      sdi <= w[cnt];
    end
    if (!sck_d && sck) begin
      sh <= {sdo, sh[7:1]};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        rx_word <= {sdo, sh[7:1]};
        n_words <= n_words + 8'h01;
      end
    end
  end
endmodule : csp_peer

// ---- verif/tb_clock_sync_serial_port.sv ----
// testbench: registers, transmit, receive and handshake of the serial port
`timescale 1ns/1ps
module tb_clock_sync_serial_port;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} csp_row_s;
  logic        ref_clk, reset, psel, penable, pwrite, cts_n, sck_x;
  logic [7:0]  paddr, p_word, p_cnt, n0;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, sck_o, sck_oe, sdo, sdi, rts_n, e;
  wire logic   sck_w;
  int          err_total, tests_run, i;
  csp_row_s    rows [12] = '{
    '{1'h0, csp_pkg::OFF_MODE, 32'h0, 32'h00, 1'h0},
    '{1'h0, csp_pkg::OFF_CTRL0, 32'h0, 32'h08, 1'h0},
    '{1'h0, csp_pkg::OFF_CTRL1, 32'h0, 32'h02, 1'h0},
    '{1'h0, csp_pkg::OFF_RATE, 32'h0, 32'h00, 1'h0},
    '{1'h0, csp_pkg::OFF_RXBUF, 32'h0, 32'h00, 1'h0},
    '{1'h0, csp_pkg::OFF_IREQ, 32'h0, 32'h00, 1'h0},
    '{1'h0, 8'h1C, 32'h0, 32'h00, 1'h1},
    '{1'h1, csp_pkg::OFF_CTRL1, 32'h1A, 32'h00, 1'h0},
    '{1'h0, csp_pkg::OFF_CTRL1, 32'h0, 32'h02, 1'h0},
    '{1'h1, csp_pkg::OFF_CTRL0, 32'h08, 32'h00, 1'h0},
    '{1'h0, csp_pkg::OFF_CTRL0, 32'h0, 32'h08, 1'h0},
    '{1'h1, 8'h1C, 32'hFF, 32'h00, 1'h1}};
  assign sck_w = sck_oe ? sck_o : sck_x;
  csp_top uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_shift_clock_in(sck_w), .serial_shift_clock_out(sck_o),
    .serial_shift_clock_oe(sck_oe), .serial_data_out(sdo), .serial_data_in(sdi),
    .clear_to_send_in_n(cts_n), .ready_to_receive_out_n(rts_n));
  csp_peer u_peer (.ref_clk(ref_clk), .sck(sck_w), .sdo(sdo), .tx_base(8'h5A), .sdi(sdi),
    .rx_word(p_word), .n_words(p_cnt));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic fail(input string s);
    err_total++;
    $display("mismatch %0t %s", $time, s);
    report_and_stop();
  endtask : fail
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) fail("bus timeout");
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic wait_words(input logic [7:0] n);
    int k;
    for (k = 0; k < 3000 && p_cnt !== n; k++) @(posedge ref_clk);
    if (p_cnt !== n) fail("word timeout");
  endtask : wait_words
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cts_n = 1'h1;
    sck_x = 1'h1;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    chk({31'h0, rts_n}, 32'h1);
    for (i = 0; i < 12; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    $display("test registers done");
    wr(csp_pkg::OFF_MODE, 32'h71);
    wr(csp_pkg::OFF_CTRL0, 32'h04);
    wr(csp_pkg::OFF_RATE, 32'h03);
    chk({31'h0, rts_n}, 32'h1);
    wr(csp_pkg::OFF_CTRL1, 32'h05);
    @(posedge ref_clk);
    chk({31'h0, rts_n}, 32'h0);
    wr(csp_pkg::OFF_TXBUF, 32'hA5);
    wr(csp_pkg::OFF_TXBUF, 32'h3C);
    rd(csp_pkg::OFF_IREQ, 32'h01);
    wait_words(8'h01);
    chk({24'h0, p_word}, 32'hA5);
    wait_words(8'h02);
    chk({24'h0, p_word}, 32'h3C);
    repeat (4) @(posedge ref_clk);
    rd(csp_pkg::OFF_CTRL0, 32'h0C);
    rd(csp_pkg::OFF_CTRL1, 32'h1F);
    rd(csp_pkg::OFF_IREQ, 32'h03);
    rd(csp_pkg::OFF_RXBUF, 32'h5B);
    rd(csp_pkg::OFF_CTRL1, 32'h07);
    chk({31'h0, rts_n}, 32'h0);
    wr(csp_pkg::OFF_IREQ, 32'h03);
    rd(csp_pkg::OFF_IREQ, 32'h00);
    $display("test back to back done");
    wr(csp_pkg::OFF_CTRL0, 32'h00);
    n0 = p_cnt;
    wr(csp_pkg::OFF_TXBUF, 32'h81);
    repeat (40) @(posedge ref_clk);
    chk({24'h0, p_cnt}, {24'h0, n0});
    rd(csp_pkg::OFF_CTRL0, 32'h08);
    rd(csp_pkg::OFF_CTRL1, 32'h05);
    cts_n <= 1'h0;
    for (i = 0; i < 300 && sck_o !== 1'h0; i++) @(posedge ref_clk);
    if (sck_o !== 1'h0) fail("start timeout");
    cts_n <= 1'h1;
    wr(csp_pkg::OFF_CTRL1, 32'h04);
    wait_words(n0 + 8'h01);
    chk({24'h0, p_word}, 32'h81);
    $display("test clear to send done");
    wr(csp_pkg::OFF_CTRL0, 32'h04);
    wr(csp_pkg::OFF_CTRL1, 32'h05);
    wr(csp_pkg::OFF_TXBUF, 32'h42);
    wait_words(n0 + 8'h02);
    chk({24'h0, p_word}, 32'h42);
    repeat (4) @(posedge ref_clk);
    rd(csp_pkg::OFF_CTRL1, 32'h1F);
    wr(csp_pkg::OFF_CTRL1, 32'h01);
    apb(1'h0, csp_pkg::OFF_CTRL1, 32'h0);
    chk(q & 32'h17, 32'h03);
    $display("test handshake and overrun done");
    wr(csp_pkg::OFF_MODE, 32'h79);
    @(posedge ref_clk);
    chk({31'h0, sck_oe}, 32'h0);
    rd(csp_pkg::OFF_RXBUF, 32'h5D);
    wr(csp_pkg::OFF_CTRL1, 32'h05);
    wr(csp_pkg::OFF_TXBUF, 32'h99);
    repeat (8) begin
      sck_x <= 1'h0;
      repeat (8) @(posedge ref_clk);
      sck_x <= 1'h1;
      repeat (8) @(posedge ref_clk);
    end
    wait_words(n0 + 8'h03);
    chk({24'h0, p_word}, 32'h99);
    repeat (4) @(posedge ref_clk);
    rd(csp_pkg::OFF_RXBUF, 32'h5E);
    $display("test external clock done");
    report_and_stop();
  end
endmodule : tb_clock_sync_serial_port
